// >>> core/cts_cfg.svh
`ifndef CTS_CFG_SVH
`define CTS_CFG_SVH

// Crystal and derived rates
`define CTS_XTAL_KHZ          27120
`define CTS_TX_KHZ            6780
`define CTS_TX_DIV            4
`define CTS_TX_HALF           2
`define CTS_PA_PAIRS          2
`define CTS_PA_GATES          4

// Clock check window, counted in loose oscillator ticks
`define CTS_CHK_WIN           16'h0040
`define CTS_CHK_LO            16'h0ae0
`define CTS_CHK_HI            16'h0c20
`define CTS_CHK_GOOD_WINS     3'h3
`define CTS_LOSS_TIMEOUT      8'h20

// Driver rail clamp
`define CTS_CLAMP_W           2
`define CTS_CLAMP_RST         2'h0

// Fixed low-rate divide
`define CTS_SLOW_DIV          8'hd8

`endif

// >>> core/cts_clock_check.sv
`timescale 1ns/1ps
`include "cts_cfg.svh"

module cts_clock_check
    import cts_pkg::*;
(
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        reset_n,
    // Control
    input  wire logic        run,
    input  wire logic        xtal_edge,
    input  wire logic        loose_tick,
    // Result
    output logic             valid,
    output logic             lost
);

    logic [15:0] xtal_cnt_q;
    logic [15:0] win_cnt_q;
    logic [2:0]  good_q;
    logic [7:0]  idle_q;
    logic        valid_q;
    logic        lost_q;
    logic        in_range;

    assign in_range = (xtal_cnt_q >= `CTS_CHK_LO) && (xtal_cnt_q <= `CTS_CHK_HI);
    assign valid    = valid_q;
    assign lost     = lost_q;

    // =========================================
    // Window counters
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            xtal_cnt_q <= 16'h0000;
            win_cnt_q  <= 16'h0000;
        end
        else if (!run)
        begin
            xtal_cnt_q <= 16'h0000;
            win_cnt_q  <= 16'h0000;
        end
        else if (loose_tick && win_cnt_q == `CTS_CHK_WIN - 16'h0001)
        begin
            xtal_cnt_q <= {15'h0000, xtal_edge};
            win_cnt_q  <= 16'h0000;
        end
        else
        begin
            if (xtal_edge)
                xtal_cnt_q <= xtal_cnt_q + 16'h0001;
            if (loose_tick)
                win_cnt_q <= win_cnt_q + 16'h0001;
        end
    end

    // =========================================
    // Qualification
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            good_q  <= 3'h0;
            valid_q <= 1'b0;
        end
        else if (!run || lost_q)
        begin
            good_q  <= 3'h0;
            valid_q <= 1'b0;
        end
        else if (loose_tick && win_cnt_q == `CTS_CHK_WIN - 16'h0001)
        begin
            if (!in_range)
            begin
                good_q  <= 3'h0;
                valid_q <= 1'b0;
            end
            else if (good_q == `CTS_CHK_GOOD_WINS - 3'h1)
                valid_q <= 1'b1;
            else
                good_q <= good_q + 3'h1;
        end
    end

    // =========================================
    // Loss detection
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            idle_q <= 8'h00;
            lost_q <= 1'b0;
        end
        else if (!run || xtal_edge)
        begin
            idle_q <= 8'h00;
            lost_q <= 1'b0;
        end
        else if (loose_tick)
        begin
            if (idle_q == `CTS_LOSS_TIMEOUT)
                lost_q <= valid_q;
            else
                idle_q <= idle_q + 8'h01;
        end
    end

endmodule

// >>> core/cts_pkg.sv
package cts_pkg;

    typedef enum logic [1:0] {
        CTS_SRC_LOOSE,
        CTS_SRC_XTAL
    } cts_src_t;

    typedef struct packed {
        logic osc_enable;
        logic buck_force_pwm;
        logic boost_request;
        logic lineup_request;
        logic [1:0] clamp_sel;
    } cts_ctrl_t;

    typedef struct packed {
        logic [1:0] clk_source;
        logic       xtal_valid;
        logic       xtal_lost;
        logic       osc_running;
        logic       core_active;
    } cts_stat_t;

endpackage

// >>> core/cts_supervisor.sv
`timescale 1ns/1ps
`include "cts_cfg.svh"


module cts_supervisor
    import cts_pkg::*;
(
    // Clock and reset
    input  wire logic                    mclk,
    input  wire logic                    reset_n,
    // Pins and analog monitors
    input  wire logic                    crystal_terminal_one,
    input  wire logic                    loose_osc_clk,
    input  wire logic                    core_input_supply_ok,
    input  wire logic                    sleep_select_input,
    input  wire logic                    temp_warning,
    input  wire logic                    temp_shutdown,
    // Host controls
    input  wire cts_ctrl_t               ctrl,
    input  wire logic                    ctrl_write,
    input  wire logic                    irq_ack,
    // Status and events
    output cts_stat_t                    status,
    output logic                         irq_thermal_warn,
    output logic                         irq_thermal_shutdown,
    // Clock products
    output logic                         xtal_clk_gate,
    output logic                         slow_tick,
    output logic [`CTS_PA_GATES-1:0]     pa_gate,
    // Function enables
    output logic                         lineup_enable,
    output logic                         boost_enable,
    output logic                         boost_clk_xtal,
    output logic                         buck_auto_mode,
    output logic                         buck_clk_xtal,
    output logic                         supplies_enable,
    output logic [`CTS_CLAMP_W-1:0]      driver_supply_rail_clamp,
    output logic                         register_clear
);

    typedef enum logic [2:0] {
        ST_OFF,
        ST_START,
        ST_CHECK,
        ST_XTAL,
        ST_SHUTDOWN
    } cts_state_t;

    cts_state_t  state_q;
    cts_state_t  state_d;

    // Synchronisers: three stages, change counted when two and three agree
    logic [2:0]  xt_s_q;
    logic [2:0]  lo_s_q;
    logic [2:0]  uv_s_q;
    logic [2:0]  sl_s_q;
    logic [2:0]  tw_s_q;
    logic [2:0]  ts_s_q;
    logic        xt_q;
    logic        lo_q;
    logic        uv_q;
    logic        sl_q;
    logic        tw_q;
    logic        ts_q;

    cts_ctrl_t   ctrl_q;
    logic        osc_en_q;
    logic        valid;
    logic        lost;
    logic        run;
    logic        xt_edge;
    logic        lo_tick;
    logic        xt_prev_q;
    logic        lo_prev_q;
    logic        tw_prev_q;
    logic        shut_seen_q;
    logic [1:0]  tx_div_q;
    logic [7:0]  slow_cnt_q;
    logic        tx_phase_q;
    logic        clk_ok;
    cts_stat_t   status_q;
    logic        warn_q;
    logic        shut_irq_q;
    logic [`CTS_PA_GATES-1:0] pa_q;
    logic        lineup_q;
    logic        boost_q;
    logic        slow_q;
    logic        clr_q;

    // =========================================
    // Input synchronisers
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            xt_s_q <= 3'h0;
            lo_s_q <= 3'h0;
            uv_s_q <= 3'h0;
            sl_s_q <= 3'h0;
            tw_s_q <= 3'h0;
            ts_s_q <= 3'h0;
        end
        else
        begin
            xt_s_q <= {xt_s_q[1:0], crystal_terminal_one};
            lo_s_q <= {lo_s_q[1:0], loose_osc_clk};
            uv_s_q <= {uv_s_q[1:0], core_input_supply_ok};
            sl_s_q <= {sl_s_q[1:0], sleep_select_input};
            tw_s_q <= {tw_s_q[1:0], temp_warning};
            ts_s_q <= {ts_s_q[1:0], temp_shutdown};
        end
    end

    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            xt_q <= 1'b0;
            lo_q <= 1'b0;
            uv_q <= 1'b0;
            sl_q <= 1'b0;
            tw_q <= 1'b0;
            ts_q <= 1'b0;
        end
        else
        begin
            if (xt_s_q[1] == xt_s_q[2])
                xt_q <= xt_s_q[2];
            if (lo_s_q[1] == lo_s_q[2])
                lo_q <= lo_s_q[2];
            if (uv_s_q[1] == uv_s_q[2])
                uv_q <= uv_s_q[2];
            if (sl_s_q[1] == sl_s_q[2])
                sl_q <= sl_s_q[2];
            if (tw_s_q[1] == tw_s_q[2])
                tw_q <= tw_s_q[2];
            if (ts_s_q[1] == ts_s_q[2])
                ts_q <= ts_s_q[2];
        end
    end

    // =========================================
    // Edge detection
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            xt_prev_q <= 1'b0;
            lo_prev_q <= 1'b0;
            tw_prev_q <= 1'b0;
        end
        else
        begin
            xt_prev_q <= xt_q;
            lo_prev_q <= lo_q;
            tw_prev_q <= tw_q;
        end
    end

    assign xt_edge = xt_q && !xt_prev_q;
    assign lo_tick = lo_q && !lo_prev_q;

    // =========================================
    // Host control registers
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            ctrl_q <= '{osc_enable: 1'b1, clamp_sel: `CTS_CLAMP_RST, default: 1'b0};
        end
        else if (!uv_q || state_q == ST_SHUTDOWN)
        begin
            ctrl_q <= '{osc_enable: 1'b1, clamp_sel: `CTS_CLAMP_RST, default: 1'b0};
        end
        else if (ctrl_write)
        begin
            ctrl_q <= ctrl;
        end
    end

    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
            osc_en_q <= 1'b0;
        else
            osc_en_q <= uv_q && ctrl_q.osc_enable && !sl_q && state_q != ST_SHUTDOWN;
    end

    // =========================================
    // Clock check
    assign run = osc_en_q;

    cts_clock_check u_check (
        .mclk       (mclk),
        .reset_n    (reset_n),
        .run        (run),
        .xtal_edge  (xt_edge),
        .loose_tick (lo_tick),
        .valid      (valid),
        .lost       (lost)
    );

    // =========================================
    // Supervisor state machine
    always_comb
    begin
        state_d = state_q;
        case (state_q)
            ST_OFF:
                if (run)
                    state_d = ST_START;
            ST_START:
                state_d = ST_CHECK;
            ST_CHECK:
                if (!run)
                    state_d = ST_OFF;
                else if (valid)
                    state_d = ST_XTAL;
            ST_XTAL:
                if (!run)
                    state_d = ST_OFF;
                else if (lost || !valid)
                    state_d = ST_CHECK;
            ST_SHUTDOWN:
                if (!ts_q)
                    state_d = ST_OFF;
            default:
                state_d = ST_OFF;
        endcase
        if (ts_q)
            state_d = ST_SHUTDOWN;
        else if (!uv_q)
            state_d = ST_OFF;
    end

    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
            state_q <= ST_OFF;
        else
            state_q <= state_d;
    end

    assign clk_ok = (state_q == ST_XTAL);

    // =========================================
    // Fixed dividers
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            tx_div_q   <= 2'h0;
            tx_phase_q <= 1'b0;
        end
        else if (!run)
        begin
            tx_div_q   <= 2'h0;
            tx_phase_q <= 1'b0;
        end
        else if (xt_edge)
        begin
            if (tx_div_q == 2'(`CTS_TX_HALF - 1))
            begin
                tx_div_q   <= 2'h0;
                tx_phase_q <= !tx_phase_q;
            end
            else
                tx_div_q <= tx_div_q + 2'h1;
        end
    end

    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            slow_cnt_q <= 8'h00;
            slow_q     <= 1'b0;
        end
        else if (!clk_ok)
        begin
            slow_cnt_q <= 8'h00;
            slow_q     <= 1'b0;
        end
        else if (xt_edge && slow_cnt_q == `CTS_SLOW_DIV - 8'h01)
        begin
            slow_cnt_q <= 8'h00;
            slow_q     <= 1'b1;
        end
        else
        begin
            if (xt_edge)
                slow_cnt_q <= slow_cnt_q + 8'h01;
            slow_q <= 1'b0;
        end
    end

    // =========================================
    // Amplifier gate drives
    genvar gi;
    generate
        for (gi = 0; gi < `CTS_PA_PAIRS; gi++)
        begin : g_pair
            always_ff @(posedge mclk or negedge reset_n)
            begin
                if (!reset_n)
                    pa_q[2*gi+1:2*gi] <= 2'h0;
                else if (!lineup_q)
                    pa_q[2*gi+1:2*gi] <= 2'h0;
                else
                    pa_q[2*gi+1:2*gi] <= {!tx_phase_q, tx_phase_q};
            end
        end
    endgenerate

    // =========================================
    // Function enables
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            lineup_q <= 1'b0;
            boost_q  <= 1'b0;
            clr_q    <= 1'b1;
        end
        else
        begin
            lineup_q <= clk_ok && ctrl_q.lineup_request;
            boost_q  <= clk_ok && ctrl_q.boost_request;
            clr_q    <= !uv_q || state_q == ST_SHUTDOWN;
        end
    end

    // =========================================
    // Status and thermal events
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
            status_q <= '0;
        else
        begin
            status_q.clk_source  <= clk_ok ? CTS_SRC_XTAL : CTS_SRC_LOOSE;
            status_q.xtal_valid  <= valid;
            status_q.xtal_lost   <= lost;
            status_q.osc_running <= run;
            status_q.core_active <= uv_q && state_q != ST_SHUTDOWN;
        end
    end

    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
            warn_q <= 1'b0;
        else if (tw_q && !tw_prev_q && uv_q)
            warn_q <= 1'b1;
        else if (irq_ack || state_q == ST_SHUTDOWN)
            warn_q <= 1'b0;
    end

    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            shut_seen_q <= 1'b0;
            shut_irq_q  <= 1'b0;
        end
        else
        begin
            if (state_q == ST_SHUTDOWN)
                shut_seen_q <= 1'b1;
            else if (shut_seen_q && uv_q)
                shut_seen_q <= 1'b0;
            if (shut_seen_q && state_q != ST_SHUTDOWN && uv_q)
                shut_irq_q <= 1'b1;
            else if (irq_ack)
                shut_irq_q <= 1'b0;
        end
    end

    // =========================================
    // Outputs
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            xtal_clk_gate  <= 1'b0;
            buck_auto_mode <= 1'b1;
            buck_clk_xtal  <= 1'b0;
            supplies_enable <= 1'b0;
            boost_clk_xtal <= 1'b0;
        end
        else
        begin
            xtal_clk_gate  <= clk_ok;
            buck_auto_mode <= !clk_ok || !ctrl_q.buck_force_pwm;
            buck_clk_xtal  <= clk_ok;
            supplies_enable <= uv_q && state_q != ST_SHUTDOWN;
            boost_clk_xtal <= clk_ok;
        end
    end

    assign status                   = status_q;
    assign irq_thermal_warn         = warn_q;
    assign irq_thermal_shutdown     = shut_irq_q;
    assign slow_tick                = slow_q;
    assign pa_gate                  = pa_q;
    assign lineup_enable            = lineup_q;
    assign boost_enable             = boost_q;
    assign driver_supply_rail_clamp = ctrl_q.clamp_sel;
    assign register_clear           = clr_q;

endmodule

// >>> test/cts_pins_model.sv
`timescale 1ns/1ps

module cts_pins_model
(
    // Clock and control
    input  wire logic       mclk,
    input  wire logic       run,
    input  wire logic [1:0] mode,
    // Pins
    output logic            crystal_terminal_one,
    output logic            loose_osc_clk
);
    // ==========
    // Crystal period 4 or 8, frozen when stopped; loose 184
    logic [2:0] xc = 3'h0;
    logic [7:0] lc = 8'h00;
    always @(negedge mclk)
    begin
        xc <= (run && mode != 2'h0) ? xc + 3'h1 : xc;
        lc <= (lc == 8'hb7) ? 8'h00 : lc + 8'h01;
    end
    assign crystal_terminal_one = (mode == 2'h2) ? xc[2] : xc[1];
    assign loose_osc_clk = (lc < 8'h5c);
endmodule

// >>> test/cts_supervisor_bench.sv
`timescale 1ns/1ps
`include "cts_cfg.svh"

module cts_supervisor_bench;
    import cts_pkg::*;
    logic mclk = 1'b0;
    logic reset_n, crystal_terminal_one, loose_osc_clk, core_input_supply_ok, sleep_select_input;
    logic temp_warning, temp_shutdown, ctrl_write, irq_ack, irq_thermal_warn, irq_thermal_shutdown;
    logic xtal_clk_gate, slow_tick, lineup_enable, boost_enable, boost_clk_xtal, buck_auto_mode;
    logic buck_clk_xtal, supplies_enable, register_clear;
    logic [`CTS_PA_GATES-1:0] pa_gate;
    logic [`CTS_CLAMP_W-1:0]  driver_supply_rail_clamp;
    logic [1:0]               mode;
    cts_ctrl_t                ctrl;
    cts_stat_t                status;
    int                       n_mismatch = 0;
    int                       num_checks = 0;

    always #12.5 mclk = ~mclk;

    cts_supervisor dut (.mclk(mclk), .reset_n(reset_n), .crystal_terminal_one(crystal_terminal_one),
        .loose_osc_clk(loose_osc_clk), .core_input_supply_ok(core_input_supply_ok),
        .sleep_select_input(sleep_select_input), .temp_warning(temp_warning), .temp_shutdown(temp_shutdown),
        .ctrl(ctrl), .ctrl_write(ctrl_write), .irq_ack(irq_ack), .status(status),
        .irq_thermal_warn(irq_thermal_warn), .irq_thermal_shutdown(irq_thermal_shutdown),
        .xtal_clk_gate(xtal_clk_gate), .slow_tick(slow_tick), .pa_gate(pa_gate),
        .lineup_enable(lineup_enable), .boost_enable(boost_enable), .boost_clk_xtal(boost_clk_xtal),
        .buck_auto_mode(buck_auto_mode), .buck_clk_xtal(buck_clk_xtal), .supplies_enable(supplies_enable),
        .driver_supply_rail_clamp(driver_supply_rail_clamp), .register_clear(register_clear));

    cts_pins_model u_pins (.mclk(mclk), .run(status.osc_running), .mode(mode),
        .crystal_terminal_one(crystal_terminal_one), .loose_osc_clk(loose_osc_clk));

    // ==========
    // Tasks
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        num_checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(negedge mclk);
    endtask

    task automatic wr(input cts_ctrl_t v);
        ctrl = v;
        ctrl_write = 1'b1;
        tick(1);
        ctrl_write = 1'b0;
    endtask

    task automatic test_done;
        if (n_mismatch == 0 && num_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    initial
    begin
        #2200000;
        n_mismatch++;
        test_done();
    end

    // ==========
    // Tests
    initial
    begin
        int   i;
        int   n;
        logic v;
        reset_n = 1'b0;
        core_input_supply_ok = 1'b0;
        sleep_select_input = 1'b0;
        temp_warning = 1'b0;
        temp_shutdown = 1'b0;
        ctrl = '0;
        ctrl_write = 1'b0;
        irq_ack = 1'b0;
        mode = 2'h2;
        tick(10);
        reset_n = 1'b1;
        tick(10);
        chk("register_clear", 16'h1, register_clear);
        chk("osc_running", 16'h0, status.osc_running);
        core_input_supply_ok = 1'b1;
        for (i = 0; i < 20 && status.osc_running !== 1'b1; i++) tick(1);
        chk("osc_running", 16'h1, status.osc_running);
        chk("core_active", 16'h1, status.core_active);
        wr({1'b1, 1'b0, 1'b1, 1'b1, 2'h2});
        chk("clamp", 16'h2, driver_supply_rail_clamp);
        tick(4);
        chk("lineup_enable", 16'h0, lineup_enable);
        chk("buck supplies", 16'h3, {buck_auto_mode, supplies_enable});
        tick(24000);
        chk("xtal_valid", 16'h0, status.xtal_valid);
        chk("clk_source", 16'h0, status.clk_source);
        mode = 2'h1;
        for (i = 0; i < 60000 && xtal_clk_gate !== 1'b1; i++) tick(1);
        tick(4);
        chk("xtal_clk_gate", 16'h1, xtal_clk_gate);
        chk("clk_source", 16'h1, status.clk_source);
        chk("enables", 16'h1f, {lineup_enable, boost_enable, boost_clk_xtal, buck_clk_xtal, buck_auto_mode});
        chk("pa_gate pairs", 16'h1, (pa_gate[0] ^ pa_gate[1]) & (pa_gate[2] ^ pa_gate[3]));
        v = pa_gate[0];
        for (i = 0; i < 20 && pa_gate[0] === v; i++) tick(1);
        v = pa_gate[0];
        for (n = 0; n < 20 && pa_gate[0] === v; n++) tick(1);
        chk("pa_gate half period", 16'h8, n[15:0]);
        for (i = 0; i < 1000 && slow_tick !== 1'b1; i++) tick(1);
        tick(1);
        for (n = 1; n < 1000 && slow_tick !== 1'b1; n++) tick(1);
        chk("slow_tick spacing", 16'h0360, n[15:0]);
        wr({1'b1, 1'b1, 1'b1, 1'b1, 2'h1});
        tick(4);
        chk("buck_auto_mode", 16'h0, buck_auto_mode);
        chk("clamp", 16'h1, driver_supply_rail_clamp);
        temp_warning = 1'b1;
        for (i = 0; i < 10 && irq_thermal_warn !== 1'b1; i++) tick(1);
        chk("warn flag", 16'h1, irq_thermal_warn);
        chk("lineup_enable", 16'h1, lineup_enable);
        temp_warning = 1'b0;
        irq_ack = 1'b1;
        tick(1);
        irq_ack = 1'b0;
        tick(2);
        chk("warn flag", 16'h0, irq_thermal_warn);
        mode = 2'h0;
        for (i = 0; i < 7400 && status.xtal_lost !== 1'b1; i++) tick(1);
        tick(4);
        chk("lost source", 16'h4, {status.xtal_lost, status.clk_source});
        chk("lineup supplies", 16'h1, {lineup_enable, supplies_enable});
        sleep_select_input = 1'b1;
        tick(8);
        chk("osc_running", 16'h0, status.osc_running);
        sleep_select_input = 1'b0;
        tick(8);
        chk("osc_running", 16'h1, status.osc_running);
        wr({1'b0, 1'b0, 1'b0, 1'b0, 2'h1});
        tick(6);
        chk("osc_running", 16'h0, status.osc_running);
        temp_shutdown = 1'b1;
        tick(8);
        chk("shutdown", 16'h2, {register_clear, supplies_enable});
        chk("clamp", 16'h0, driver_supply_rail_clamp);
        wr({1'b1, 1'b0, 1'b0, 1'b0, 2'h3});
        tick(2);
        chk("clamp", 16'h0, driver_supply_rail_clamp);
        temp_shutdown = 1'b0;
        for (i = 0; i < 20 && irq_thermal_shutdown !== 1'b1; i++) tick(1);
        tick(4);
        chk("shutdown flag", 16'h1, irq_thermal_shutdown);
        chk("restart", 16'h3, {supplies_enable, status.osc_running});
        core_input_supply_ok = 1'b0;
        tick(8);
        chk("lockout", 16'h2, {register_clear, status.core_active});
        test_done();
    end
endmodule

bind cts_supervisor cts_supervisor_chk u_chk (.mclk(mclk), .reset_n(reset_n),
    .crystal_terminal_one(crystal_terminal_one), .loose_osc_clk(loose_osc_clk),
    .core_input_supply_ok(core_input_supply_ok), .sleep_select_input(sleep_select_input),
    .temp_warning(temp_warning), .temp_shutdown(temp_shutdown), .ctrl(ctrl), .ctrl_write(ctrl_write),
    .irq_ack(irq_ack), .status(status), .irq_thermal_warn(irq_thermal_warn),
    .irq_thermal_shutdown(irq_thermal_shutdown), .xtal_clk_gate(xtal_clk_gate), .slow_tick(slow_tick),
    .pa_gate(pa_gate), .lineup_enable(lineup_enable), .boost_enable(boost_enable),
    .boost_clk_xtal(boost_clk_xtal), .buck_auto_mode(buck_auto_mode), .buck_clk_xtal(buck_clk_xtal),
    .supplies_enable(supplies_enable), .driver_supply_rail_clamp(driver_supply_rail_clamp),
    .register_clear(register_clear));

// >>> test/cts_supervisor_chk.sv
`timescale 1ns/1ps
`include "cts_cfg.svh"

module cts_supervisor_chk
    import cts_pkg::*;
(
    // Clock, pins and controls
    input wire logic                       mclk,
    input wire logic                       reset_n,
    input wire logic                       crystal_terminal_one,
    input wire logic                       loose_osc_clk,
    input wire logic                       core_input_supply_ok,
    input wire logic                       sleep_select_input,
    input wire logic                       temp_warning,
    input wire logic                       temp_shutdown,
    input wire cts_ctrl_t                  ctrl,
    input wire logic                       ctrl_write,
    input wire logic                       irq_ack,
    // Status, clocks and enables
    input wire cts_stat_t                  status,
    input wire logic                       irq_thermal_warn,
    input wire logic                       irq_thermal_shutdown,
    input wire logic                       xtal_clk_gate,
    input wire logic                       slow_tick,
    input wire logic [`CTS_PA_GATES-1:0]   pa_gate,
    input wire logic                       lineup_enable,
    input wire logic                       boost_enable,
    input wire logic                       boost_clk_xtal,
    input wire logic                       buck_auto_mode,
    input wire logic                       buck_clk_xtal,
    input wire logic                       supplies_enable,
    input wire logic [`CTS_CLAMP_W-1:0]    driver_supply_rail_clamp,
    input wire logic                       register_clear
);
    // ==========
    // Crystal edges between gate toggles
    logic       xt_q;
    logic       pa_q;
    logic       rise;
    logic [3:0] cnt_q;
    logic [1:0] seen_q;
    assign rise = crystal_terminal_one & ~xt_q;
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            xt_q   <= 1'b0;
            pa_q   <= 1'b0;
            cnt_q  <= 4'h0;
            seen_q <= 2'h0;
        end
        else
        begin
            xt_q  <= crystal_terminal_one;
            pa_q  <= pa_gate[0];
            cnt_q <= (pa_gate[0] != pa_q) ? 4'h0 : cnt_q + {3'h0, rise};
            if (!xtal_clk_gate)
                seen_q <= 2'h0;
            else if (pa_gate[0] != pa_q && seen_q != 2'h3)
                seen_q <= seen_q + 2'h1;
        end
    end

    // ==========
    // Properties
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);

    property p_clamp;
        ctrl_write && status.core_active && !register_clear |=> driver_supply_rail_clamp == $past(ctrl.clamp_sel);
    endproperty
    a_clamp: assert property (p_clamp) else $error("clamp not loaded");
    property p_pa_pair;
        xtal_clk_gate [*3] |-> pa_gate[1] == !pa_gate[0] && pa_gate[3] == !pa_gate[2];
    endproperty
    a_pa_pair: assert property (p_pa_pair) else $error("gate pair not complementary");
    property p_pa_rate;
        pa_gate[0] != pa_q && seen_q >= 2'h2 |-> cnt_q + {3'h0, rise} == 4'h2;
    endproperty
    a_pa_rate: assert property (p_pa_rate) else $error("gate toggle spacing wrong");
    property p_no_clk;
        status.clk_source == CTS_SRC_LOOSE [*4] |-> !lineup_enable && !boost_enable && buck_auto_mode && !buck_clk_xtal;
    endproperty
    a_no_clk: assert property (p_no_clk) else $error("function runs without crystal");
    property p_src;
        xtal_clk_gate [*2] |-> status.clk_source == CTS_SRC_XTAL;
    endproperty
    a_src: assert property (p_src) else $error("source status wrong");
    property p_first;
        $rose(xtal_clk_gate) |-> $past(status.xtal_valid) || $past(status.xtal_valid, 2);
    endproperty
    a_first: assert property (p_first) else $error("crystal used before check");
    property p_loss;
        $rose(status.xtal_lost) |-> ##[0:3] status.clk_source == CTS_SRC_LOOSE && !xtal_clk_gate;
    endproperty
    a_loss: assert property (p_loss) else $error("lost crystal still used");
    property p_warn;
        $rose(temp_warning) && status.core_active && !register_clear |-> ##[1:6] irq_thermal_warn;
    endproperty
    a_warn: assert property (p_warn) else $error("warning flag missing");
    property p_shut;
        temp_shutdown [*8] |-> register_clear && !supplies_enable && !lineup_enable && driver_supply_rail_clamp == 2'h0;
    endproperty
    a_shut: assert property (p_shut) else $error("shutdown left functions on");
    property p_lock;
        !core_input_supply_ok [*8] |-> register_clear && !status.core_active;
    endproperty
    a_lock: assert property (p_lock) else $error("core active below lockout");
    property p_sleep;
        sleep_select_input [*8] |-> !status.osc_running;
    endproperty
    a_sleep: assert property (p_sleep) else $error("oscillator runs in sleep");
endmodule
